/* design/smem_cmd.v */
// Purpose: command interpreter for user-zone read/write and system write
// Assumes: one received byte per rx handshake, one sent byte per tx handshake
// Notes:   memory, access rights and checksum check sit outside this block
`timescale 1ns/1ns
`include "smem_consts.vh"

module smem_cmd #(
  parameter PAGE_SIZE    = 16,             // bytes per page of this variant
  parameter ZONE_SIZE    = 128,            // bytes per user zone
  parameter ZONE_COUNT   = 4,              // number of user zones
  parameter WRITE_CYCLES = `WRITE_CYCLES   // self-timed write length
) (
  // clock, reset, enable
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        enable_i,
  // received byte stream
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_data_i,
  output wire        rx_ready_o,
  // transmitted byte stream
  output wire        tx_valid_o,
  output wire [7:0]  tx_data_o,
  input  wire        tx_ready_i,
  // access rights and security state
  input  wire        user_write_ok_i,   // zone write permitted
  input  wire        user_read_ok_i,    // zone read permitted
  input  wire [1:0]  auth_mode_field_i, // zone write authentication mode
  input  wire        cfg_write_ok_i,    // config address at cfg_addr_o permitted
  input  wire        unlock_ok_i,       // unlock code already verified
  input  wire        csum_valid_i,      // checksum just received is valid
  // memory port
  output reg  [7:0]  mem_addr_o,
  output reg  [7:0]  mem_wdata_o,
  output reg         mem_stage_o,       // pulse: stage byte into page buffer
  output reg         mem_commit_o,      // pulse: start write cycle
  output reg         mem_discard_o,     // pulse: drop staged bytes
  output reg         mem_cfg_o,         // staged bytes target config memory
  input  wire [7:0]  mem_rdata_i,
  output reg         mem_rd_o,          // pulse: read byte at mem_addr_o
  // state outputs
  output wire [7:0]  cfg_addr_o,        // config address under check
  output reg  [3:0]  fuse_o,            // fuse byte low nibble, zero = blown
  output reg  [7:0]  zone_o,
  output reg         anti_tear_o,
  output reg         auth_revoke_o,     // pulse: wrong checksum
  output reg         busy_o             // write cycle running
);

  // states
  localparam S_HDR   = 4'd0;  // collect header
  localparam S_DEC   = 4'd1;  // decode header
  localparam S_DATA  = 4'd2;  // receive data bytes
  localparam S_WRITE = 4'd3;  // self-timed write
  localparam S_RDREQ = 4'd4;  // request read byte
  localparam S_RDGET = 4'd5;  // capture read byte
  localparam S_SW1   = 4'd6;  // queue status first byte
  localparam S_SW2   = 4'd7;  // queue status second byte
  localparam S_CSCHK = 4'd8;  // checksum verdict

  reg [3:0]  state_reg;
  reg [2:0]  hdr_cnt_reg;     // header byte index
  reg [7:0]  ins_reg;         // instruction
  reg [7:0]  p1_reg;          // first parameter
  reg [7:0]  p2_reg;          // start address or selector
  reg [7:0]  len_reg;         // byte count
  reg [7:0]  cnt_reg;         // bytes left
  reg [7:0]  sw_reg;          // pending status first byte
  reg        cfg_bad_reg;     // config run touched a forbidden address
  reg        pend_reg;        // user write waits for checksum
  reg [31:0] wait_reg;        // write cycle countdown
  reg        q_push;          // push one byte into the tx buffer
  reg [7:0]  q_byte;          // byte pushed

  // two-entry output buffer
  reg [7:0]  buf_mem [0:1];
  reg        wr_ptr_reg;
  reg        rd_ptr_reg;
  reg [1:0]  fill_reg;
  wire       buf_full  = (fill_reg == 2'd2);
  wire       buf_empty = (fill_reg == 2'd0);

  assign tx_valid_o = !buf_empty;
  assign tx_data_o  = buf_mem[rd_ptr_reg];
  assign cfg_addr_o = mem_addr_o;

  // bytes are taken only while collecting header or data
  assign rx_ready_o = enable_i && (state_reg == S_HDR || state_reg == S_DATA);
  wire rx_take = rx_valid_i && rx_ready_o;

  // wrap an address within the current zone
  function [7:0] zone_next;
    input [7:0] a;
    begin
      if (a == ZONE_SIZE - 1)
        zone_next = 8'h00;
      else
        zone_next = a + 8'h01;
    end
  endfunction

  // buffer pointers and storage; a stall on tx holds the interpreter
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg   <= 2'd0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else if (enable_i) begin
      if (q_push) begin
        buf_mem[wr_ptr_reg] <= q_byte;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (tx_ready_i && !buf_empty)
        rd_ptr_reg <= ~rd_ptr_reg;
      fill_reg <= fill_reg + {1'b0, q_push} - {1'b0, tx_ready_i && !buf_empty};
    end
  end

  // main sequencer
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= S_HDR;
      hdr_cnt_reg   <= 3'd0;
      ins_reg       <= 8'h00;
      p1_reg        <= 8'h00;
      p2_reg        <= 8'h00;
      len_reg       <= 8'h00;
      cnt_reg       <= 8'h00;
      sw_reg        <= `SW_OK;
      cfg_bad_reg   <= 1'b0;
      pend_reg      <= 1'b0;
      wait_reg      <= 32'd0;
      q_push        <= 1'b0;
      q_byte        <= 8'h00;
      mem_addr_o    <= 8'h00;
      mem_wdata_o   <= 8'h00;
      mem_stage_o   <= 1'b0;
      mem_commit_o  <= 1'b0;
      mem_discard_o <= 1'b0;
      mem_cfg_o     <= 1'b0;
      mem_rd_o      <= 1'b0;
      fuse_o        <= `FUSE_RESET;
      zone_o        <= 8'h00;
      anti_tear_o   <= 1'b0;
      auth_revoke_o <= 1'b0;
      busy_o        <= 1'b0;
    end else if (enable_i) begin
      // pulses default low
      q_push        <= 1'b0;
      mem_stage_o   <= 1'b0;
      mem_commit_o  <= 1'b0;
      mem_discard_o <= 1'b0;
      mem_rd_o      <= 1'b0;
      auth_revoke_o <= 1'b0;
      case (state_reg)
        // header: class, ins, p1, p2, p3; class ignored
        S_HDR: begin
          if (rx_take) begin
            case (hdr_cnt_reg)
              3'd1: ins_reg <= rx_data_i;
              3'd2: p1_reg  <= rx_data_i;
              3'd3: begin
                p2_reg     <= rx_data_i;
                // start address must stand before decode checks access
                mem_addr_o <= rx_data_i;
              end
              default: len_reg <= rx_data_i;
            endcase
            if (hdr_cnt_reg == 3'd4) begin
              hdr_cnt_reg <= 3'd0;
              state_reg   <= S_DEC;
            end else
              hdr_cnt_reg <= hdr_cnt_reg + 3'd1;
          end
        end
        // decide procedure byte or early status
        S_DEC: begin
          if (!buf_full) begin
            state_reg   <= S_SW2;
            sw_reg      <= `SW_OK;
            q_push      <= 1'b1;
            cnt_reg     <= len_reg;
            mem_addr_o  <= p2_reg;
            cfg_bad_reg <= 1'b0;
            mem_cfg_o   <= 1'b0;
            q_byte      <= ins_reg;
            case (ins_reg)
              `INS_WRITE_USER: begin
                if (!user_write_ok_i)
                  q_byte <= `SW_UNAUTH;
                else if (len_reg == 8'h00 || len_reg > PAGE_SIZE ||
                         (anti_tear_o && len_reg > `AT_MAX_LEN))
                  q_byte <= `SW_BAD_LEN;
                else if (p2_reg >= ZONE_SIZE)
                  q_byte <= `SW_BAD_ADDR;
                else
                  state_reg <= S_DATA;
              end
              `INS_READ_USER: begin
                if (!user_read_ok_i)
                  q_byte <= `SW_UNAUTH;
                else if (p2_reg >= ZONE_SIZE)
                  q_byte <= `SW_BAD_ADDR;
                else begin
                  q_push    <= 1'b0;
                  q_byte    <= ins_reg;
                  state_reg <= S_RDREQ;
                  q_push    <= 1'b1;
                end
              end
              `INS_SYS_WRITE: begin
                case (p1_reg)
                  `FN_CFG_WRITE, `FN_CFG_WRITE_AT: begin
                    mem_cfg_o <= 1'b1;
                    if (!cfg_write_ok_i)
                      q_byte <= `SW_UNAUTH;
                    else if (len_reg == 8'h00 || len_reg > PAGE_SIZE ||
                             (p1_reg == `FN_CFG_WRITE_AT && len_reg > `AT_MAX_LEN))
                      q_byte <= `SW_BAD_LEN;
                    else
                      state_reg <= S_DATA;
                  end
                  `FN_FUSE_PROG: begin
                    state_reg <= S_SW1;
                    q_push    <= 1'b0;
                    sw_reg    <= `SW_UNAUTH;
                    if (unlock_ok_i) begin
                      // clear only, in order
                      if (p2_reg == `FUSE_SEL_FACTORY) begin
                        fuse_o[`FUSE_BIT_FACTORY] <= 1'b0;
                        sw_reg <= `SW_OK;
                      end else if (p2_reg == `FUSE_SEL_MAKER &&
                                   !fuse_o[`FUSE_BIT_FACTORY]) begin
                        fuse_o[`FUSE_BIT_MAKER] <= 1'b0;
                        sw_reg <= `SW_OK;
                      end else if (p2_reg == `FUSE_SEL_FINAL &&
                                   !fuse_o[`FUSE_BIT_MAKER]) begin
                        fuse_o[`FUSE_BIT_FINAL] <= 1'b0;
                        sw_reg <= `SW_OK;
                      end
                    end
                  end
                  `FN_CHECKSUM: begin
                    if (len_reg != `CSUM_LEN)
                      q_byte <= `SW_BAD_LEN;
                    else
                      state_reg <= S_DATA;
                  end
                  `FN_ZONE_SEL, `FN_ZONE_SEL_AT: begin
                    q_push <= 1'b0;
                    if (p2_reg >= ZONE_COUNT) begin
                      q_push <= 1'b1;
                      q_byte <= `SW_BAD_ADDR;
                    end else begin
                      zone_o      <= p2_reg;
                      anti_tear_o <= (p1_reg == `FN_ZONE_SEL_AT);
                      pend_reg    <= 1'b0;
                      state_reg   <= S_SW1;
                    end
                  end
                  default: q_byte <= `SW_BAD_ADDR;
                endcase
              end
              default: q_byte <= `SW_BAD_INS;
            endcase
            // any early status leaves a 00 second byte
            if (state_reg != S_DEC)
              state_reg <= S_HDR;
          end
        end
        // data bytes stage at successive addresses; checksum bytes are only counted, not staged
        S_DATA: begin
          if (rx_take) begin
            cnt_reg <= cnt_reg - 8'h01;
            if (ins_reg == `INS_SYS_WRITE && p1_reg == `FN_CHECKSUM) begin
              if (cnt_reg == 8'h01)
                state_reg <= S_CSCHK;
            end else begin
              mem_wdata_o <= rx_data_i;
              mem_stage_o <= 1'b1;
              if (mem_cfg_o && !cfg_write_ok_i)
                cfg_bad_reg <= 1'b1;
              if (cnt_reg == 8'h01) begin
                if (mem_cfg_o && (cfg_bad_reg || !cfg_write_ok_i)) begin
                  mem_discard_o <= 1'b1;
                  sw_reg        <= `SW_UNAUTH;
                  state_reg     <= S_SW1;
                end else if (!mem_cfg_o && !auth_mode_field_i[1]) begin
                  pend_reg  <= 1'b1;
                  sw_reg    <= `SW_WAIT_CSUM;
                  state_reg <= S_SW1;
                end else begin
                  mem_commit_o <= 1'b1;
                  state_reg    <= S_WRITE;
                end
              end
            end
          end
          // advance after each staged byte
          if (mem_stage_o)
            mem_addr_o <= mem_addr_o + 8'h01;
        end
        // checksum verdict gates the pending write
        S_CSCHK: begin
          if (csum_valid_i && pend_reg) begin
            pend_reg     <= 1'b0;
            mem_commit_o <= 1'b1;
            state_reg    <= S_WRITE;
          end else begin
            if (!csum_valid_i)
              auth_revoke_o <= 1'b1;
            if (pend_reg)
              mem_discard_o <= 1'b1;
            pend_reg  <= 1'b0;
            sw_reg    <= csum_valid_i ? `SW_OK : `SW_UNAUTH;
            state_reg <= S_SW1;
          end
        end
        // self-timed write cycle
        S_WRITE: begin
          if (!busy_o) begin
            busy_o   <= 1'b1;
            wait_reg <= WRITE_CYCLES - 1;
          end else if (wait_reg == 32'd0) begin
            busy_o    <= 1'b0;
            sw_reg    <= `SW_OK;
            state_reg <= S_SW1;
          end else
            wait_reg <= wait_reg - 32'd1;
        end
        // read: fetch, then queue, address wraps in zone
        S_RDREQ: begin
          if (cnt_reg == 8'h00 && len_reg != 8'h00) begin
            sw_reg    <= `SW_OK;
            state_reg <= S_SW1;
          end else begin
            mem_rd_o  <= 1'b1;
            state_reg <= S_RDGET;
          end
        end
        S_RDGET: begin
          if (!buf_full && !mem_rd_o) begin
            q_push     <= 1'b1;
            q_byte     <= mem_rdata_i;
            mem_addr_o <= zone_next(mem_addr_o);
            cnt_reg    <= cnt_reg - 8'h01;
            len_reg    <= 8'h01;
            state_reg  <= S_RDREQ;
          end
        end
        // final status word
        S_SW1: begin
          if (!buf_full) begin
            q_push    <= 1'b1;
            q_byte    <= sw_reg;
            state_reg <= S_SW2;
          end
        end
        S_SW2: begin
          if (!buf_full && !q_push) begin
            q_push    <= 1'b1;
            q_byte    <= `SW_LOW;
            state_reg <= S_HDR;
          end
        end
        default: state_reg <= S_HDR;
      endcase
    end
  end

endmodule

/* design/smem_consts.vh */
// Purpose: constants for the secure memory command interpreter
// Assumes: byte-wide character stream already de-serialised
// Notes:   all offsets, codes and timing counts live here
`ifndef SMEM_CONSTS_VH
`define SMEM_CONSTS_VH
// instruction codes
`define INS_WRITE_USER   8'hB0
`define INS_READ_USER    8'hB2
`define INS_SYS_WRITE    8'hB4
// system write functions
`define FN_CFG_WRITE     8'h00
`define FN_FUSE_PROG     8'h01
`define FN_CHECKSUM      8'h02
`define FN_ZONE_SEL      8'h03
`define FN_CFG_WRITE_AT  8'h08
`define FN_ZONE_SEL_AT   8'h0B
// fuse selectors and bit positions
`define FUSE_SEL_FACTORY 8'h06
`define FUSE_SEL_MAKER   8'h04
`define FUSE_SEL_FINAL   8'h00
`define FUSE_BIT_FACTORY 0
`define FUSE_BIT_MAKER   1
`define FUSE_BIT_FINAL   2
`define FUSE_RESET       4'hF
// status first bytes, second byte always 00
`define SW_OK            8'h90
`define SW_WAIT_CSUM     8'h62
`define SW_BAD_LEN       8'h67
`define SW_UNAUTH        8'h69
`define SW_BAD_ADDR      8'h6B
`define SW_BAD_INS       8'h6D
`define SW_LOW           8'h00
// anti-tearing byte limit and checksum length
`define AT_MAX_LEN       8'h08
`define CSUM_LEN         8'h02
// write cycle time in microseconds, and clock rate in MHz
`define WRITE_TIME_US    5000
`define CLOCK_MHZ        100
`define WRITE_CYCLES     (`WRITE_TIME_US * `CLOCK_MHZ)
`endif

/* verification/smem_cmd_chk.sv */
// Purpose: port assertions for the command interpreter
// Assumes: bench holds unlock and checksum levels over a command
// Notes:   bound into every smem_cmd instance
`timescale 1ns/1ns
module smem_cmd_chk #(
  parameter WRITE_CYCLES = 20
) (
  // clock and reset
  input wire       clock_i,
  input wire       rst_n_i,
  // byte streams
  input wire       rx_ready_o,
  input wire       tx_valid_o,
  input wire [7:0] tx_data_o,
  input wire       tx_ready_i,
  // security levels
  input wire       unlock_ok_i,
  input wire       csum_valid_i,
  // memory and state
  input wire       mem_stage_o,
  input wire       mem_commit_o,
  input wire       mem_discard_o,
  input wire       mem_cfg_o,
  input wire [3:0] fuse_o,
  input wire       anti_tear_o,
  input wire       auth_revoke_o,
  input wire       busy_o
);
  reg [31:0] busy_cnt_reg;  // cycles of the running write
  reg [7:0]  stage_cnt_reg; // bytes staged since commit or discard
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // helper counters
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_reg <= 32'h0;
      stage_cnt_reg <= 8'h00;
    end else begin
      busy_cnt_reg <= busy_o ? busy_cnt_reg + 32'h1 : 32'h0;
      if (mem_commit_o || mem_discard_o) stage_cnt_reg <= 8'h00;
      else if (mem_stage_o) stage_cnt_reg <= stage_cnt_reg + 8'h01;
    end
  end
  fuse_mono_a: assert property ((fuse_o & ~$past(fuse_o)) == 4'h0)
    else $error("fuse bit went back to one");
  factory_first_a: assert property ($fell(fuse_o[1]) |-> !$past(fuse_o[0]))
    else $error("maker fuse blown before factory fuse");
  maker_first_a: assert property ($fell(fuse_o[2]) |-> !$past(fuse_o[1]))
    else $error("final fuse blown before maker fuse");
  fuse_unlock_a: assert property ($changed(fuse_o) |-> $past(unlock_ok_i))
    else $error("fuse changed while locked");
  busy_len_a: assert property ($fell(busy_o) |-> busy_cnt_reg == WRITE_CYCLES)
    else $error("write cycle length wrong");
  commit_busy_a: assert property (mem_commit_o |-> ##[0:2] busy_o)
    else $error("commit without write cycle");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("sent byte dropped before accept");
  busy_refuse_a: assert property (busy_o |-> !rx_ready_o)
    else $error("byte taken during write cycle");
  revoke_cause_a: assert property (auth_revoke_o |-> !csum_valid_i)
    else $error("revoke on valid checksum");
  revoke_pulse_a: assert property (auth_revoke_o |=> !auth_revoke_o)
    else $error("revoke longer than one cycle");
  commit_excl_a: assert property (mem_commit_o |-> !mem_discard_o)
    else $error("commit and discard together");
  tear_len_a: assert property (mem_stage_o && anti_tear_o && !mem_cfg_o |-> stage_cnt_reg < 8'h08)
    else $error("anti-tearing write above eight bytes");
  // main scenarios reached
  cover property ($rose(busy_o));
  cover property ($changed(fuse_o));
  cover property (auth_revoke_o);
  cover property ($rose(anti_tear_o));
endmodule
bind smem_cmd smem_cmd_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.clock_i, .rst_n_i,
  .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .unlock_ok_i, .csum_valid_i,
  .mem_stage_o, .mem_commit_o, .mem_discard_o, .mem_cfg_o, .fuse_o, .anti_tear_o,
  .auth_revoke_o, .busy_o);

/* verification/host_model.sv */
// Purpose: card reader side of the byte streams
// Assumes: bench calls put and get just after a rising edge
// Notes:   slow_reg makes the reader stall before each accept
`timescale 1ns/1ns
module host_model (
  // clock and reset
  input  wire       clock_i,
  input  wire       rst_n_i,
  // bytes toward the device
  output reg        rx_valid_i,
  output reg  [7:0] rx_data_i,
  input  wire       rx_ready_o,
  // bytes from the device
  input  wire       tx_valid_o,
  input  wire [7:0] tx_data_o,
  output reg        tx_ready_i
);
  reg     slow_reg; // stall three cycles before accepting
  integer wait_cnt; // bounded handshake wait
  initial begin
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    tx_ready_i = 1'b0;
    slow_reg = 1'b0;
  end
  // hand one byte over and hold it until taken
  task put(input [7:0] b);
    begin
      @(posedge clock_i);
      #1;
      rx_valid_i = 1'b1;
      rx_data_i = b;
      wait_cnt = 0;
      while (rx_ready_o !== 1'b1 && wait_cnt < 100) begin
        @(posedge clock_i);
        #1;
        wait_cnt = wait_cnt + 1;
      end
      @(posedge clock_i);
      #1;
      rx_valid_i = 1'b0;
      rx_data_i = ~b; // released line shows the inverse, not the old byte
    end
  endtask
  // accept one byte, optionally after a stall
  task get(output [7:0] b);
    begin
      @(posedge clock_i);
      #1;
      if (slow_reg) begin
        repeat (3) @(posedge clock_i);
        #1;
      end
      tx_ready_i = 1'b1;
      wait_cnt = 0;
      while (tx_valid_o !== 1'b1 && wait_cnt < 1000) begin
        @(posedge clock_i);
        #1;
        wait_cnt = wait_cnt + 1;
      end
      b = tx_data_o;
      @(posedge clock_i);
      #1;
      tx_ready_i = 1'b0;
    end
  endtask
endmodule

/* verification/tb.sv */
// Purpose: self-checking bench for the command interpreter
// Assumes: write cycle shortened to 20 clocks
// Notes:   memory model returns address xor A5
`timescale 1ns/1ns
module tb;
  reg        clock_i, rst_n_i, user_write_ok_i, user_read_ok_i, unlock_ok_i, csum_valid_i;
  reg  [1:0] auth_mode_field_i; // 11 means no checksum needed
  reg  [7:0] mem_rdata_i;       // memory read model
  wire       rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, mem_stage_o, mem_commit_o;
  wire       mem_discard_o, mem_cfg_o, mem_rd_o, anti_tear_o, auth_revoke_o, busy_o;
  wire [7:0] rx_data_i, tx_data_o, mem_addr_o, mem_wdata_o, cfg_addr_o, zone_o;
  wire [3:0] fuse_o;
  wire       cfg_write_ok_i = (cfg_addr_o < 8'h14); // config above 13 forbidden
  integer    bad_count, samples_checked, cyc, commits, revokes, discards, i;
  reg  [7:0] b;
  reg  [7:0] st_a[$], st_d[$]; // staged addresses and data
  smem_cmd #(.WRITE_CYCLES(20)) dut (.clock_i, .rst_n_i, .enable_i(1'b1), .rx_valid_i,
    .rx_data_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .user_write_ok_i,
    .user_read_ok_i, .auth_mode_field_i, .cfg_write_ok_i, .unlock_ok_i, .csum_valid_i,
    .mem_addr_o, .mem_wdata_o, .mem_stage_o, .mem_commit_o, .mem_discard_o, .mem_cfg_o,
    .mem_rdata_i, .mem_rd_o, .cfg_addr_o, .fuse_o, .zone_o, .anti_tear_o, .auth_revoke_o,
    .busy_o);
  host_model host (.clock_i, .rst_n_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o,
    .tx_data_o, .tx_ready_i);
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // memory model, event monitors and hang limit
  always @(posedge clock_i) begin
    mem_rdata_i <= mem_addr_o ^ 8'hA5;
    if (mem_stage_o === 1'b1) begin
      st_a.push_back(mem_addr_o);
      st_d.push_back(mem_wdata_o);
    end
    if (mem_commit_o === 1'b1) commits = commits + 1;
    if (auth_revoke_o === 1'b1) revokes = revokes + 1;
    if (mem_discard_o === 1'b1) discards = discards + 1;
    cyc = cyc + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // header: class, instruction, parameter, address or selector, length
  task cmd(input [7:0] ins, input [7:0] p1, input [7:0] p2, input [7:0] p3);
    begin
      host.put(8'h00);
      host.put(ins);
      host.put(p1);
      host.put(p2);
      host.put(p3);
    end
  endtask
  task one(input [7:0] e);
    begin
      host.get(b);
      check(b, e);
    end
  endtask
  task sw(input [7:0] e);
    begin
      one(e);
      one(8'h00);
    end
  endtask
  // header, procedure byte, then n data bytes 30, 31 ...
  task xfer(input [7:0] ins, input [7:0] p1, input [7:0] p2, input [7:0] n);
    begin
      cmd(ins, p1, p2, n);
      one(ins);
      for (i = 0; i < n; i = i + 1) host.put(8'(8'h30 + i));
    end
  endtask
  task t_write;
    begin
      cmd(8'hB4, 8'h03, 8'h01, 8'h00);
      sw(8'h90);
      check(zone_o, 8'h01);
      st_a.delete();
      st_d.delete();
      commits = 0;
      xfer(8'hB0, 8'h00, 8'h02, 8'h04);
      sw(8'h90);
      check(8'(commits), 8'h01);
      check(8'(st_a.size()), 8'h04);
      for (i = 0; i < 4; i = i + 1) begin
        check(st_a[i], 8'(8'h02 + i));
        check(st_d[i], 8'(8'h30 + i));
      end
    end
  endtask
  task t_tear;
    begin
      cmd(8'hB4, 8'h0B, 8'h00, 8'h00);
      sw(8'h90);
      check({7'h00, anti_tear_o}, 8'h01);
      cmd(8'hB0, 8'h00, 8'h00, 8'h09);
      sw(8'h67);
      xfer(8'hB0, 8'h00, 8'h00, 8'h08);
      sw(8'h90);
      cmd(8'hB4, 8'h03, 8'h00, 8'h00);
      sw(8'h90);
      check({7'h00, anti_tear_o}, 8'h00);
      cmd(8'hB0, 8'h00, 8'h00, 8'h11);
      sw(8'h67);
    end
  endtask
  task t_read;
    begin
      host.slow_reg = 1'b1; // reader stalls, buffer fills
      cmd(8'hB2, 8'h00, 8'h7E, 8'h04);
      one(8'hB2);
      for (i = 0; i < 4; i = i + 1) one(8'((8'h7E + i) & 8'h7F) ^ 8'hA5);
      sw(8'h90);
      host.slow_reg = 1'b0;
      user_read_ok_i = 1'b0;
      cmd(8'hB2, 8'h00, 8'h00, 8'h04);
      sw(8'h69);
      user_read_ok_i = 1'b1;
    end
  endtask
  task t_error;
    begin
      cmd(8'hC0, 8'h00, 8'h00, 8'h00);
      sw(8'h6D);
      cmd(8'hB4, 8'h05, 8'h00, 8'h00);
      sw(8'h6B);
      cmd(8'hB4, 8'h03, 8'h05, 8'h00);
      sw(8'h6B);
      check(zone_o, 8'h00);
      cmd(8'hB0, 8'h00, 8'h80, 8'h04);
      sw(8'h6B);
      user_write_ok_i = 1'b0;
      cmd(8'hB0, 8'h00, 8'h00, 8'h04);
      sw(8'h69);
      user_write_ok_i = 1'b1;
    end
  endtask
  // one fuse request with unlock level, expected status and fuses
  task fz(input u, input [7:0] sel, input [7:0] e, input [3:0] f);
    begin
      unlock_ok_i = u;
      cmd(8'hB4, 8'h01, sel, 8'h00);
      sw(e);
      check({4'h0, fuse_o}, {4'h0, f});
    end
  endtask
  task t_fuse;
    begin
      fz(1'b0, 8'h06, 8'h69, 4'hF);
      fz(1'b1, 8'h04, 8'h69, 4'hF);
      fz(1'b1, 8'h06, 8'h90, 4'hE);
      fz(1'b1, 8'h00, 8'h69, 4'hE);
      fz(1'b1, 8'h04, 8'h90, 4'hC);
      fz(1'b1, 8'h00, 8'h90, 4'h8);
    end
  endtask
  task t_csum;
    begin
      auth_mode_field_i = 2'b01;
      commits = 0;
      revokes = 0;
      xfer(8'hB0, 8'h00, 8'h10, 8'h02);
      sw(8'h62);
      csum_valid_i = 1'b0;
      xfer(8'hB4, 8'h02, 8'h00, 8'h02);
      sw(8'h69);
      check(8'(revokes), 8'h01);
      xfer(8'hB0, 8'h00, 8'h10, 8'h02);
      sw(8'h62);
      check(8'(commits), 8'h00);
      csum_valid_i = 1'b1;
      xfer(8'hB4, 8'h02, 8'h00, 8'h02);
      sw(8'h90);
      check(8'(commits), 8'h01);
      auth_mode_field_i = 2'b11;
    end
  endtask
  task t_cfg;
    begin
      commits = 0;
      discards = 0;
      xfer(8'hB4, 8'h00, 8'h12, 8'h04);
      sw(8'h69);
      check(8'(commits), 8'h00);
      check(8'(discards), 8'h01);
      cmd(8'hB4, 8'h00, 8'h20, 8'h02);
      sw(8'h69);
      xfer(8'hB4, 8'h08, 8'h00, 8'h02);
      sw(8'h90);
      check(8'(commits), 8'h01);
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // reset for two cycles, then every scenario in turn
  initial begin
    bad_count = 0;
    samples_checked = 0;
    cyc = 0;
    commits = 0;
    revokes = 0;
    discards = 0;
    rst_n_i = 1'b0;
    user_write_ok_i = 1'b1;
    user_read_ok_i = 1'b1;
    unlock_ok_i = 1'b0;
    csum_valid_i = 1'b0;
    auth_mode_field_i = 2'b11;
    mem_rdata_i = 8'h00;
    repeat (2) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    t_write;
    t_tear;
    t_read;
    t_error;
    t_fuse;
    t_csum;
    t_cfg;
    complete_run;
  end
endmodule
